// *** testbench/awc_tb.sv ***
// Purpose: Self-checking bench for the converter window check and amplifier control.
// Assumes: APB answers in the first access cycle; the bench still waits for pready.
// Notes: Outputs are sampled at the rising edge, before that edge's updates land.
`timescale 1ns/10ps
`default_nettype none
`include "awc_params.svh"
module testbench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic conv_done = 1'b0;
   logic [11:0] conversion_result = 12'h000;
   logic [3:0] amp_event_trig = 4'h0;
   logic conversion_end_irq;
   logic irq;
   logic snooze_enable;
   logic resolution_select;
   logic internal_source_select;
   logic [4:0] adc_channel;
   logic ref_current_enable;
   logic speed_mode_bit;
   logic [3:0] amp_on;
   int n_mismatch = 0;
   int n_compared = 0;
   logic [31:0] rd;
   logic er;
   logic [11:0] ra [11] = '{`AWC_OFF_CONV_CTRL, `AWC_OFF_UPPER, `AWC_OFF_LOWER, `AWC_OFF_CHANNEL,
      `AWC_OFF_AMP_EN, `AWC_OFF_AMP_SPEED, `AWC_OFF_AMP_ROUTE, `AWC_OFF_AMP_TRIG,
      `AWC_OFF_IRQ_STATUS, `AWC_OFF_IRQ_MASK, `AWC_OFF_STATE};
   logic [7:0] rv [11] = '{8'h00, 8'hff, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00};
   logic [7:0] win [4] = '{8'h3f, 8'h40, 8'h80, 8'h81};
   int tl [3] = '{0, 1, 3};
   logic exp_hit;

   awc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .conv_done(conv_done), .conversion_result(conversion_result),
      .amp_event_trig(amp_event_trig), .conversion_end_irq(conversion_end_irq), .irq(irq),
      .snooze_enable(snooze_enable), .resolution_select(resolution_select),
      .internal_source_select(internal_source_select), .adc_channel(adc_channel),
      .ref_current_enable(ref_current_enable), .speed_mode_bit(speed_mode_bit), .amp_on(amp_on));

   always #2.5 pclk = ~pclk;

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Waits for pready rather than trusting the one-cycle answer
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) chk("pready", 32'h1, 32'h0);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask

   task rchk(input logic [11:0] a, input logic [7:0] exp, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, {24'h0, exp}, rd);
   endtask

   task conv(input logic [11:0] v, input logic exp, input string nm);
      @(posedge pclk);
      conv_done <= 1'b1;
      conversion_result <= v;
      @(posedge pclk);
      conv_done <= 1'b0;
      @(posedge pclk);
      chk(nm, {31'h0, exp}, {31'h0, conversion_end_irq});
   endtask

   task pulse(input logic [3:0] m);
      repeat (2) @(posedge pclk);
      amp_event_trig <= m;
      @(posedge pclk);
      amp_event_trig <= 4'h0;
      repeat (3) @(posedge pclk);
   endtask

   task conclude;
      $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Whole run needs a few hundred cycles; this leaves ample margin
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      conclude;
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      chk("adc_channel reset", 32'h07, {27'h0, adc_channel});
      for (int i = 0; i < 11; i++) rchk(ra[i], rv[i], "reset value");
      chk("mapped err", 32'h0, {31'h0, er});
      apb(1'b0, 12'h0fc, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, er});
      chk("unmapped data", 32'h0, rd);
      $display("Test reset and map done");
      wr(`AWC_OFF_CONV_CTRL, 8'h0d);
      wr(`AWC_OFF_AMP_SPEED, 8'hff);
      wr(`AWC_OFF_AMP_ROUTE, 8'hff);
      wr(`AWC_OFF_CHANNEL, 8'h12);
      repeat (3) @(posedge pclk);
      chk("snooze", 32'h1, {31'h0, snooze_enable});
      chk("resolution", 32'h1, {31'h0, resolution_select});
      chk("speed", 32'h1, {31'h0, speed_mode_bit});
      chk("ext channel", 32'h12, {26'h0, internal_source_select, adc_channel});
      rchk(`AWC_OFF_AMP_ROUTE, 8'h03, "route field");
      rchk(`AWC_OFF_AMP_SPEED, 8'h80, "speed reg");
      wr(`AWC_OFF_CHANNEL, 8'h81);
      wr(`AWC_OFF_CONV_CTRL, 8'h00);
      wr(`AWC_OFF_AMP_SPEED, 8'h00);
      repeat (3) @(posedge pclk);
      chk("int channel", 32'h21, {26'h0, internal_source_select, adc_channel});
      chk("snooze off", 32'h0, {31'h0, snooze_enable});
      chk("resolution off", 32'h0, {31'h0, resolution_select});
      chk("speed off", 32'h0, {31'h0, speed_mode_bit});
      $display("Test control fields done");
      wr(`AWC_OFF_UPPER, 8'h80);
      wr(`AWC_OFF_LOWER, 8'h40);
      // A write with lane 0 disabled must leave the bound alone
      pstrb <= 4'he;
      wr(`AWC_OFF_UPPER, 8'h11);
      pstrb <= 4'hf;
      rchk(`AWC_OFF_UPPER, 8'h80, "strobe off write");
      for (int res = 0; res < 2; res++) begin
         for (int rc = 0; rc < 2; rc++) begin
            wr(`AWC_OFF_CONV_CTRL, {4'h0, rc[0], 2'b00, res[0]});
            for (int i = 0; i < 4; i++) begin
               exp_hit = (i == 1 || i == 2) ^ rc[0];
               // 12-bit results compare their top byte, 8-bit ones their low byte
               if (res == 1) conv({4'ha, win[i]}, exp_hit, "window 8bit");
               else conv({win[i], 4'hf}, exp_hit, "window 12bit");
            end
         end
      end
      $display("Test window compare done");
      // Back to the inside test so that a mid-window result is a hit
      wr(`AWC_OFF_CONV_CTRL, 8'h01);
      wr(`AWC_OFF_IRQ_STATUS, 8'h07);
      wr(`AWC_OFF_IRQ_MASK, 8'h01);
      conv(12'h060, 1'b1, "hit for irq");
      repeat (2) @(posedge pclk);
      chk("irq raised", 32'h1, {31'h0, irq});
      rchk(`AWC_OFF_IRQ_STATUS, 8'h01, "status set");
      wr(`AWC_OFF_IRQ_STATUS, 8'h01);
      repeat (2) @(posedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      wr(`AWC_OFF_IRQ_MASK, 8'h00);
      conv(12'h060, 1'b1, "masked hit");
      repeat (2) @(posedge pclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      rchk(`AWC_OFF_IRQ_STATUS, 8'h01, "status masked");
      $display("Test interrupt done");
      wr(`AWC_OFF_AMP_EN, 8'h81);
      repeat (4) @(posedge pclk);
      chk("sw run", 32'h1, {28'h0, amp_on});
      chk("ref current", 32'h1, {31'h0, ref_current_enable});
      wr(`AWC_OFF_AMP_EN, 8'h00);
      repeat (4) @(posedge pclk);
      chk("sw stop", 32'h0, {28'h0, amp_on});
      chk("ref off", 32'h0, {31'h0, ref_current_enable});
      wr(`AWC_OFF_AMP_TRIG, 8'h40);
      for (int r = 0; r < 4; r++) begin
         for (int j = 0; j < 3; j++) begin
            wr(`AWC_OFF_AMP_ROUTE, r[7:0]);
            wr(`AWC_OFF_AMP_EN, 8'h00);
            wr(`AWC_OFF_AMP_EN, 8'h08);
            pulse(4'h1 << tl[j]);
            exp_hit = (r == 0 && tl[j] == 3) || (r == 1 && tl[j] == 1) || (r == 3 && tl[j] == 0);
            chk("unit3 routed", {31'h0, exp_hit}, {31'h0, amp_on[3]});
         end
      end
      $display("Test event routing done");
      wr(`AWC_OFF_AMP_EN, 8'h00);
      wr(`AWC_OFF_AMP_TRIG, 8'h0c);
      wr(`AWC_OFF_AMP_ROUTE, 8'h03);
      wr(`AWC_OFF_CONV_CTRL, 8'h01);
      wr(`AWC_OFF_IRQ_STATUS, 8'h07);
      wr(`AWC_OFF_AMP_EN, 8'h02);
      repeat (4) @(posedge pclk);
      chk("armed idle", 32'h0, {28'h0, amp_on});
      pulse(4'h1);
      chk("combined start", 32'h2, {28'h0, amp_on});
      conv(12'h060, 1'b1, "stop hit");
      repeat (3) @(posedge pclk);
      chk("combined stop", 32'h0, {28'h0, amp_on});
      rchk(`AWC_OFF_IRQ_STATUS, 8'h07, "amp events");
      pulse(4'h1);
      chk("restart", 32'h2, {28'h0, amp_on});
      $display("Test combined mode done");
      conclude;
   end
endmodule // testbench
`default_nettype wire

// *** verilog/awc_amp_unit.sv ***
// Purpose: Start/stop sequencing of one amplifier unit.
// Assumes: event_trig and conv_end are one-cycle pulses.
// Notes: A prohibited trigger mode keeps the unit stopped.
`timescale 1ns/10ps
`default_nettype none
module awc_amp_unit
   import awc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic unit_enable_bit,
   input wire logic [1:0] trig_mode,
   input wire logic event_trig,
   input wire logic conv_end,
   output logic amp_on,
   output logic started,
   output logic auto_stopped
);
   awc_amp_state_t state, next_state;
   awc_trig_mode_t mode;

   assign mode = awc_trig_mode_t'(trig_mode);

   always_comb begin
      next_state = state;
      case (state)
         AWC_OFF: begin
            if (unit_enable_bit && mode == AWC_TM_SW)
               next_state = AWC_RUN;
            else if (unit_enable_bit && (mode == AWC_TM_EVT || mode == AWC_TM_EVT_AD))
               next_state = AWC_ARMED;
         end
         AWC_ARMED: begin
            if (!unit_enable_bit || mode == AWC_TM_BAD)
               next_state = AWC_OFF;
            else if (mode == AWC_TM_SW || event_trig)
               next_state = AWC_RUN;
         end
         AWC_RUN: begin
            if (!unit_enable_bit || mode == AWC_TM_BAD)
               next_state = AWC_OFF;
            else if (mode == AWC_TM_EVT_AD && conv_end)
               next_state = AWC_ARMED;
         end
         default: next_state = AWC_OFF;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         state <= AWC_OFF;
      else
         state <= next_state;
   end

   assign amp_on = state[2];
   assign started = (state == AWC_ARMED) && (next_state == AWC_RUN);
   assign auto_stopped = (state == AWC_RUN) && (next_state == AWC_ARMED);

   disabled_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      !unit_enable_bit |=> !amp_on)
      else $error("unit runs while its enable is clear");
   event_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == AWC_ARMED && unit_enable_bit && event_trig && mode == AWC_TM_EVT_AD |=> amp_on)
      else $error("armed unit did not start on its event");
   conv_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      amp_on && unit_enable_bit && mode == AWC_TM_EVT_AD && conv_end |=> !amp_on ##1 1)
      else $error("unit did not stop on conversion end");
endmodule // awc_amp_unit
`default_nettype wire

// *** verilog/awc_params.svh ***
// Purpose: Register map, field positions and reset values of the converter/amplifier control.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses.
// Functional notes
// - Range check select 0: conversion end irq fires only when lower <= result <= upper.
// - With range check select at 1 it fires only for result < lower or result > upper.
// - The snooze enable bit turns snooze-mode conversion on when 1 and leaves it unused when 0.
// - The resolution select bit gives 12-bit results at 0 and 8-bit results at 1.
// - Upper and lower bounds are two separate 8-bit software-writable registers.
// - Internal source select 0: the 5-bit channel code picks external inputs 0-13 and 16-18.
// - Internal source select 1: code 0 routes the temperature sensor, code 1 the reference.
// - Bit 7 of the amplifier control register enables the shared reference current when 1.
// - Each of four unit enable bits stops its unit at 0; at 1 it runs (software mode) or arms.
// - One shared speed mode bit selects low-power low-speed at 0 and high-speed at 1.
// - The event routing register holds a 2-bit field in bits 1:0, upper six bits read zero.
// - Routing 00 gives each unit its own trigger, 01 pairs, 11 all on trigger 0, 10 prohibited.
// - In combined mode an armed unit starts on its event and stops on a conversion end trigger.
`ifndef AWC_PARAMS_SVH
`define AWC_PARAMS_SVH

`define AWC_OFF_CONV_CTRL 12'h000
`define AWC_OFF_UPPER 12'h004
`define AWC_OFF_LOWER 12'h008
`define AWC_OFF_CHANNEL 12'h00c
`define AWC_OFF_AMP_EN 12'h010
`define AWC_OFF_AMP_SPEED 12'h014
`define AWC_OFF_AMP_ROUTE 12'h018
`define AWC_OFF_AMP_TRIG 12'h01c
`define AWC_OFF_IRQ_STATUS 12'h020
`define AWC_OFF_IRQ_MASK 12'h024
`define AWC_OFF_STATE 12'h028

`define AWC_BIT_RANGE 3
`define AWC_BIT_SNOOZE 2
`define AWC_BIT_RES 0
`define AWC_BIT_ISS 7
`define AWC_BIT_IREF 7
`define AWC_BIT_SPEED 7

`define AWC_CONV_CTRL_MASK 8'h0d
`define AWC_CHANNEL_MASK 8'h9f
`define AWC_AMP_EN_MASK 8'h8f
`define AWC_AMP_SPEED_MASK 8'h80
`define AWC_ROUTE_MASK 8'h03
`define AWC_IRQ_MASK_BITS 8'h07

`define AWC_RST_UPPER 8'hff
`define AWC_RST_LOWER 8'h00
`define AWC_RST_CHANNEL 8'h07
`define AWC_RST_ZERO 8'h00

`define AWC_IRQ_CONV 0
`define AWC_IRQ_START 1
`define AWC_IRQ_STOP 2

`endif

// *** verilog/awc_pkg.sv ***
// Purpose: Types shared by the converter/amplifier control.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes: State codes are one-hot.
`default_nettype none
package awc_pkg;
   typedef enum logic [2:0] {
      AWC_OFF = 3'b001,
      AWC_ARMED = 3'b010,
      AWC_RUN = 3'b100
   } awc_amp_state_t;
   typedef enum logic [1:0] {
      AWC_TM_SW = 2'b00,
      AWC_TM_EVT = 2'b01,
      AWC_TM_BAD = 2'b10,
      AWC_TM_EVT_AD = 2'b11
   } awc_trig_mode_t;
   typedef enum logic [1:0] {
      AWC_RT_OWN = 2'b00,
      AWC_RT_PAIR = 2'b01,
      AWC_RT_BAD = 2'b10,
      AWC_RT_ALL = 2'b11
   } awc_route_t;
endpackage
`default_nettype wire

// *** verilog/awc_top.sv ***
// Purpose: APB register file and control for the converter window check and amplifier units.
// Assumes: Converter and trigger inputs are synchronous to pclk; conv_done is a one-cycle pulse.
// Notes: Every access answers with pready in its first access cycle.
`timescale 1ns/10ps
`default_nettype none
`include "awc_params.svh"
module awc_top
   import awc_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int UNITS = 4
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic conv_done,
   input wire logic [11:0] conversion_result,
   input wire logic [UNITS-1:0] amp_event_trig,
   output logic conversion_end_irq,
   output logic irq,
   output logic snooze_enable,
   output logic resolution_select,
   output logic internal_source_select,
   output logic [4:0] adc_channel,
   output logic ref_current_enable,
   output logic speed_mode_bit,
   output logic [UNITS-1:0] amp_on
);
   logic [7:0] conv_ctrl;
   logic [7:0] result_upper_bound;
   logic [7:0] result_lower_bound;
   logic [7:0] input_channel_select;
   logic [7:0] amplifier_enable_control;
   logic [7:0] amplifier_speed_mode;
   logic [7:0] amplifier_event_routing;
   logic [7:0] amp_trigger_mode_control;
   logic [7:0] irq_status;
   logic [7:0] irq_mask;
   logic [UNITS-1:0] amp_run;
   logic [UNITS-1:0] unit_started;
   logic [UNITS-1:0] unit_stopped;
   logic [UNITS-1:0] routed_trig;
   logic window_hit;
   logic conv_event;
   logic setup;
   logic wr_access;
   logic [ADDR_W-1:0] word_addr;
   logic mapped;
   logic [7:0] rd_byte;
   logic [7:0] wr_byte;
   logic [7:0] irq_set;
   logic [7:0] irq_clr;
   logic [7:0] next_irq_status;

   // Register address decode used by both read and write paths
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
      hit = (a == off[ADDR_W-1:0]);
   endfunction

   // A channel code is legal only if it is one of the listed inputs
   function automatic logic channel_legal(input logic [7:0] sel);
      if (sel[`AWC_BIT_ISS])
         channel_legal = (sel[4:0] == 5'h00) || (sel[4:0] == 5'h01);
      else
         channel_legal = (sel[4:0] <= 5'h0d) || ((sel[4:0] >= 5'h10) && (sel[4:0] <= 5'h12));
   endfunction

   // Trigger bit feeding a given unit under a routing code
   function automatic logic route_trig(input logic [1:0] code, input int unit,
                                       input logic [UNITS-1:0] trig);
      awc_route_t rt;
      rt = awc_route_t'(code);
      case (rt)
         AWC_RT_OWN: route_trig = trig[unit];
         AWC_RT_PAIR: route_trig = trig[unit / 2];
         AWC_RT_ALL: route_trig = trig[0];
         default: route_trig = 1'b0;
      endcase
   endfunction

   // APB decode: word-aligned address, write lane 0 carries the 8-bit register data
   assign setup = psel && !penable;
   assign wr_access = psel && penable && pready && pwrite;
   assign word_addr = {paddr[ADDR_W-1:2], 2'b00};
   assign wr_byte = pwdata[7:0];
   assign mapped = hit(word_addr, `AWC_OFF_CONV_CTRL) || hit(word_addr, `AWC_OFF_UPPER)
                   || hit(word_addr, `AWC_OFF_LOWER) || hit(word_addr, `AWC_OFF_CHANNEL)
                   || hit(word_addr, `AWC_OFF_AMP_EN) || hit(word_addr, `AWC_OFF_AMP_SPEED)
                   || hit(word_addr, `AWC_OFF_AMP_ROUTE) || hit(word_addr, `AWC_OFF_AMP_TRIG)
                   || hit(word_addr, `AWC_OFF_IRQ_STATUS) || hit(word_addr, `AWC_OFF_IRQ_MASK)
                   || hit(word_addr, `AWC_OFF_STATE);

   assign rd_byte = hit(word_addr, `AWC_OFF_CONV_CTRL) ? conv_ctrl :
                    hit(word_addr, `AWC_OFF_UPPER) ? result_upper_bound :
                    hit(word_addr, `AWC_OFF_LOWER) ? result_lower_bound :
                    hit(word_addr, `AWC_OFF_CHANNEL) ? input_channel_select :
                    hit(word_addr, `AWC_OFF_AMP_EN) ? amplifier_enable_control :
                    hit(word_addr, `AWC_OFF_AMP_SPEED) ? amplifier_speed_mode :
                    hit(word_addr, `AWC_OFF_AMP_ROUTE) ? amplifier_event_routing :
                    hit(word_addr, `AWC_OFF_AMP_TRIG) ? amp_trigger_mode_control :
                    hit(word_addr, `AWC_OFF_IRQ_STATUS) ? irq_status :
                    hit(word_addr, `AWC_OFF_IRQ_MASK) ? irq_mask :
                    hit(word_addr, `AWC_OFF_STATE) ?
                       {3'b000, !channel_legal(input_channel_select), amp_run[3:0]} :
                    `AWC_RST_ZERO;

   // Zero-wait slave: pready rises in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup && !mapped;
         prdata <= (setup && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_ctrl <= `AWC_RST_ZERO;
         result_upper_bound <= `AWC_RST_UPPER;
         result_lower_bound <= `AWC_RST_LOWER;
         input_channel_select <= `AWC_RST_CHANNEL;
         amplifier_enable_control <= `AWC_RST_ZERO;
         amplifier_speed_mode <= `AWC_RST_ZERO;
         amplifier_event_routing <= `AWC_RST_ZERO;
         amp_trigger_mode_control <= `AWC_RST_ZERO;
         irq_mask <= `AWC_RST_ZERO;
      end else if (wr_access && pstrb[0]) begin
         if (hit(word_addr, `AWC_OFF_CONV_CTRL))
            conv_ctrl <= wr_byte & `AWC_CONV_CTRL_MASK;
         if (hit(word_addr, `AWC_OFF_UPPER))
            result_upper_bound <= wr_byte;
         if (hit(word_addr, `AWC_OFF_LOWER))
            result_lower_bound <= wr_byte;
         if (hit(word_addr, `AWC_OFF_CHANNEL))
            input_channel_select <= wr_byte & `AWC_CHANNEL_MASK;
         if (hit(word_addr, `AWC_OFF_AMP_EN))
            amplifier_enable_control <= wr_byte & `AWC_AMP_EN_MASK;
         if (hit(word_addr, `AWC_OFF_AMP_SPEED))
            amplifier_speed_mode <= wr_byte & `AWC_AMP_SPEED_MASK;
         if (hit(word_addr, `AWC_OFF_AMP_ROUTE))
            amplifier_event_routing <= wr_byte & `AWC_ROUTE_MASK;
         if (hit(word_addr, `AWC_OFF_AMP_TRIG))
            amp_trigger_mode_control <= wr_byte;
         if (hit(word_addr, `AWC_OFF_IRQ_MASK))
            irq_mask <= wr_byte & `AWC_IRQ_MASK_BITS;
      end
   end

   awc_window_cmp u_window (
      .pclk(pclk),
      .presetn(presetn),
      .conversion_result(conversion_result),
      .resolution_select(conv_ctrl[`AWC_BIT_RES]),
      .range_check_select(conv_ctrl[`AWC_BIT_RANGE]),
      .upper(result_upper_bound),
      .lower(result_lower_bound),
      .window_hit(window_hit)
   );

   assign conv_event = conv_done && window_hit;

   genvar g;
   generate
      for (g = 0; g < UNITS; g++) begin : g_unit
         assign routed_trig[g] = route_trig(amplifier_event_routing[1:0], g, amp_event_trig);
         awc_amp_unit u_amp (
            .pclk(pclk),
            .presetn(presetn),
            .unit_enable_bit(amplifier_enable_control[g]),
            .trig_mode(amp_trigger_mode_control[2*g+1:2*g]),
            .event_trig(routed_trig[g]),
            .conv_end(conv_event),
            .amp_on(amp_run[g]),
            .started(unit_started[g]),
            .auto_stopped(unit_stopped[g])
         );
      end
   endgenerate

   // Sticky status: a set in the same cycle as a write-one clear wins
   assign irq_set = {5'b00000, |unit_stopped, |unit_started, conv_event};
   assign irq_clr = (wr_access && pstrb[0] && hit(word_addr, `AWC_OFF_IRQ_STATUS)) ?
                    (wr_byte & `AWC_IRQ_MASK_BITS) : `AWC_RST_ZERO;
   assign next_irq_status = (irq_status & ~irq_clr) | irq_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= `AWC_RST_ZERO;
         irq <= 1'b0;
         conversion_end_irq <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq <= |(next_irq_status & irq_mask);
         conversion_end_irq <= conv_event;
      end
   end

   // Control outputs registered so the analog side sees glitch-free levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         snooze_enable <= 1'b0;
         resolution_select <= 1'b0;
         internal_source_select <= 1'b0;
         adc_channel <= 5'(`AWC_RST_CHANNEL);
         ref_current_enable <= 1'b0;
         speed_mode_bit <= 1'b0;
         amp_on <= '0;
      end else begin
         snooze_enable <= conv_ctrl[`AWC_BIT_SNOOZE];
         resolution_select <= conv_ctrl[`AWC_BIT_RES];
         internal_source_select <= input_channel_select[`AWC_BIT_ISS];
         adc_channel <= input_channel_select[4:0];
         ref_current_enable <= amplifier_enable_control[`AWC_BIT_IREF];
         speed_mode_bit <= amplifier_speed_mode[`AWC_BIT_SPEED];
         amp_on <= amp_run;
      end
   end

   conv_irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      conversion_end_irq |-> $past(conv_done) && $past(window_hit))
      else $error("conversion end irq without a window hit");
   route_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
      amplifier_event_routing[7:2] == 6'b000000)
      else $error("routing register upper bits not zero");
   route_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
      amplifier_event_routing[1:0] == 2'b01 |-> routed_trig[3] == amp_event_trig[1])
      else $error("paired routing wrong for unit 3");
   route_bad_a: assert property (@(posedge pclk) disable iff (!presetn)
      amplifier_event_routing[1:0] == 2'b10 |-> routed_trig == '0)
      else $error("prohibited routing passed a trigger");
   iref_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 ref_current_enable == $past(amplifier_enable_control[`AWC_BIT_IREF]))
      else $error("reference current does not follow its bit");
   snooze_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 snooze_enable == $past(conv_ctrl[`AWC_BIT_SNOOZE]))
      else $error("snooze enable does not follow its bit");
   speed_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 speed_mode_bit == $past(amplifier_speed_mode[`AWC_BIT_SPEED]))
      else $error("speed mode does not follow its bit");
   bound_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_access && pstrb[0] && hit(word_addr, `AWC_OFF_UPPER) |=>
         result_upper_bound == $past(pwdata[7:0]))
      else $error("upper bound write lost");
   apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready ##1 !pready)
      else $error("pready not a single access cycle");
endmodule // awc_top
`default_nettype wire

// *** verilog/awc_window_cmp.sv ***
// Purpose: Window comparison of a conversion result against the 8-bit bounds.
// Assumes: A 12-bit result is compared on its upper 8 bits, an 8-bit one on bits 7:0.
// Notes: Purely combinational; the clock only serves the checks.
`timescale 1ns/10ps
`default_nettype none
module awc_window_cmp
   import awc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] conversion_result,
   input wire logic resolution_select,
   input wire logic range_check_select,
   input wire logic [7:0] upper,
   input wire logic [7:0] lower,
   output logic window_hit
);
   logic [7:0] value;
   logic below_window;
   logic above_window;
   logic inside_window;

   assign value = resolution_select ? conversion_result[7:0] : conversion_result[11:4];
   assign below_window = value < lower;
   assign above_window = value > upper;
   assign inside_window = !below_window && !above_window;
   assign window_hit = range_check_select ? (below_window || above_window) : inside_window;

   // Checks work from the raw result so a wrong byte select is caught too
   inside_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
      !range_check_select && (resolution_select ?
         (conversion_result[7:0] >= lower && conversion_result[7:0] <= upper) :
         (conversion_result[11:4] >= lower && conversion_result[11:4] <= upper)) |-> window_hit)
      else $error("inside value did not hit");
   outside_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
      range_check_select && window_hit |-> (resolution_select ?
         (conversion_result[7:0] < lower || conversion_result[7:0] > upper) :
         (conversion_result[11:4] < lower || conversion_result[11:4] > upper)))
      else $error("outside hit on a value within bounds");
endmodule // awc_window_cmp
`default_nettype wire
